/* File: core/tdm_pkg.sv */
// constants, register map and types for the tdd mode switch and tx delay block
package tdm_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned SETTLE_NS     = 2000;                 // chain wake or standby time
    localparam int unsigned SETTLE_CYC    = (SETTLE_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned SYNC_LAT_CYC  = 3;                    // pin to active output edges
    // data widths
    localparam int unsigned SMP_W         = 16;
    localparam int unsigned LANE_W        = 16;
    localparam int unsigned ADR_W         = 8;
    // register byte offsets
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_DELAY_A   = 8'h04;
    localparam logic [7:0]  REG_DELAY_B   = 8'h08;
    localparam logic [7:0]  REG_NCO_F0    = 8'h0C;
    localparam logic [7:0]  REG_NCO_F1    = 8'h10;
    localparam logic [7:0]  REG_STATUS    = 8'h14;
    // ctrl fields
    localparam int unsigned CTRL_BOTH_FB  = 0;                    // both enables high: 1 = fb
    localparam int unsigned CTRL_NCO_SEL  = 1;
    localparam logic [1:0]  CTRL_RST      = 2'h0;
    // delay fields
    localparam int unsigned DLY_COARSE_LSB = 0;
    localparam int unsigned DLY_COARSE_W   = 3;
    localparam int unsigned DLY_FINE_LSB   = 8;
    localparam int unsigned DLY_FINE_W     = 5;
    localparam logic [2:0]  COARSE_MAX     = 3'h4;
    localparam logic [5:0]  HALF_STEP_CYC  = 6'h2;                // half input sample period
    localparam logic [12:0] DELAY_RST      = 13'h0000;
    localparam int unsigned DLY_DEPTH      = 40;                  // 4 * 2 + 31 + 1 taps
    // observation oscillator: 1 kHz raster at the clock rate
    localparam int unsigned NCO_W          = 14;
    localparam logic [13:0] NCO_MOD        = 14'(CLK_HZ / 1000);
    localparam logic [13:0] NCO_F_RST      = 14'h0000;
    // lane source, one-hot
    typedef enum logic [2:0] {
        LANE_OFF = 3'b001,
        LANE_RX  = 3'b010,
        LANE_FB  = 3'b100
    } tdm_lane_t;
endpackage

/* File: core/tdm_core.sv */
// tdd mode switch, lane routing, tx delay lines and observation oscillators
`timescale 1ns/1ps
module tdm_core
    import tdm_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              tx_path_enable_a_i,
    input  wire logic              tx_path_enable_b_i,
    input  wire logic              rx_path_enable_a_i,
    input  wire logic              rx_path_enable_b_i,
    input  wire logic              observation_enable_i,
    output logic                   tx_active_a_o,
    output logic                   tx_active_b_o,
    output logic                   rx_active_a_o,
    output logic                   rx_active_b_o,
    output logic                   obs_active_o,
    input  wire logic [SMP_W-1:0]  tx_a_i_i,
    input  wire logic [SMP_W-1:0]  tx_a_q_i,
    input  wire logic [SMP_W-1:0]  tx_b_i_i,
    input  wire logic [SMP_W-1:0]  tx_b_q_i,
    output logic      [SMP_W-1:0]  tx_a_i_o,
    output logic      [SMP_W-1:0]  tx_a_q_o,
    output logic      [SMP_W-1:0]  tx_b_i_o,
    output logic      [SMP_W-1:0]  tx_b_q_o,
    input  wire logic [LANE_W-1:0] rx_lane_data_i,
    input  wire logic [LANE_W-1:0] obs_lane_data_i,
    output logic      [LANE_W-1:0] serial_out_lane_o,
    output logic      [2:0]        lane_src_o,
    output logic      [NCO_W-1:0]  observation_mixer_osc_o
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // merge write data into a register under wishbone byte selects
    function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // delay tap from a delay field: coarse clamped to 4 and doubled, plus fine
    function automatic logic [5:0] delay_tap(input logic [12:0] dly);
        logic [2:0] crs;
        logic [5:0] fin;
        crs = dly[DLY_COARSE_LSB +: DLY_COARSE_W];
        fin = {1'b0, dly[DLY_FINE_LSB +: DLY_FINE_W]};
        if (crs > COARSE_MAX) begin
            crs = COARSE_MAX;
        end
        return 6'({3'h0, crs} * HALF_STEP_CYC) + fin;
    endfunction

    // one step of a modulo oscillator; wraps exactly at the 1 kHz raster
    function automatic logic [NCO_W-1:0] nco_step(input logic [NCO_W-1:0] acc,
                                                  input logic [NCO_W-1:0] frq);
        logic [NCO_W:0] f_eff;
        logic [NCO_W:0] sum;
        f_eff = {1'b0, frq};
        if (f_eff >= {1'b0, NCO_MOD}) begin
            f_eff = f_eff - {1'b0, NCO_MOD};
        end
        sum = {1'b0, acc} + f_eff;
        if (sum >= {1'b0, NCO_MOD}) begin
            sum = sum - {1'b0, NCO_MOD};
        end
        return sum[NCO_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [4:0]        en_meta_r;
    logic [4:0]        en_sync_r;
    logic [1:0]        ctrl_r;
    logic [12:0]       delay_a_r;
    logic [12:0]       delay_b_r;
    logic [NCO_W-1:0]  nco_f0_r;
    logic [NCO_W-1:0]  nco_f1_r;
    logic [NCO_W-1:0]  nco_acc0_r;
    logic [NCO_W-1:0]  nco_acc1_r;
    logic [31:0]       dly_a_r [0:DLY_DEPTH-1];
    logic [31:0]       dly_b_r [0:DLY_DEPTH-1];
    logic              rx_en_s;
    logic              fb_en_s;
    logic              wb_req_s;
    tdm_lane_t         lane_nxt;

    assign wb_req_s = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rx_en_s  = en_sync_r[2] || en_sync_r[3];
    assign fb_en_s  = en_sync_r[4];

    ////////////////////////////////////////////////////////////////////////////
    // enable synchronisers: order tx_a, tx_b, rx_a, rx_b, obs

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_meta_r <= 5'h00;
            en_sync_r <= 5'h00;
        end else begin
            en_meta_r <= {observation_enable_i, rx_path_enable_b_i, rx_path_enable_a_i,
                          tx_path_enable_b_i, tx_path_enable_a_i};
            en_sync_r <= en_meta_r;
        end
    end

    // chain power state, each chain on its own enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_active_a_o <= 1'b0;
            tx_active_b_o <= 1'b0;
            rx_active_a_o <= 1'b0;
            rx_active_b_o <= 1'b0;
            obs_active_o  <= 1'b0;
        end else begin
            tx_active_a_o <= en_sync_r[0];
            tx_active_b_o <= en_sync_r[1];
            rx_active_a_o <= en_sync_r[2];
            rx_active_b_o <= en_sync_r[3];
            obs_active_o  <= en_sync_r[4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lane routing

    // lane source from the synchronised enables
    always_comb begin
        lane_nxt = LANE_OFF;
        if (rx_en_s && !fb_en_s) begin
            lane_nxt = LANE_RX;
        end else if (!rx_en_s && fb_en_s) begin
            lane_nxt = LANE_FB;
        end else if (rx_en_s && fb_en_s) begin
            lane_nxt = ctrl_r[CTRL_BOTH_FB] ? LANE_FB : LANE_RX;
        end
    end

    // registered lane data and source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lane_src_o        <= LANE_OFF;
            serial_out_lane_o <= 16'h0000;
        end else begin
            lane_src_o <= lane_nxt;
            case (lane_nxt)
                LANE_RX: serial_out_lane_o <= rx_lane_data_i;
                LANE_FB: serial_out_lane_o <= obs_lane_data_i;
                default: serial_out_lane_o <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tx delay lines: i and q travel as one word, one line per chain

    // shift lines; cleared at reset so latency is the same every start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < DLY_DEPTH; k++) begin
                dly_a_r[k] <= 32'h0000_0000;
                dly_b_r[k] <= 32'h0000_0000;
            end
        end else begin
            dly_a_r[0] <= {tx_a_i_i, tx_a_q_i};
            dly_b_r[0] <= {tx_b_i_i, tx_b_q_i};
            for (int k = 1; k < DLY_DEPTH; k++) begin
                dly_a_r[k] <= dly_a_r[k-1];
                dly_b_r[k] <= dly_b_r[k-1];
            end
        end
    end

    // tap outputs; a chain in standby sends zeros
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_a_i_o <= 16'h0000;
            tx_a_q_o <= 16'h0000;
            tx_b_i_o <= 16'h0000;
            tx_b_q_o <= 16'h0000;
        end else begin
            {tx_a_i_o, tx_a_q_o} <= en_sync_r[0] ? dly_a_r[delay_tap(delay_a_r)]
                                                 : 32'h0000_0000;
            {tx_b_i_o, tx_b_q_o} <= en_sync_r[1] ? dly_b_r[delay_tap(delay_b_r)]
                                                 : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // observation oscillators: both keep running so phase is held

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nco_acc0_r              <= 14'h0000;
            nco_acc1_r              <= 14'h0000;
            observation_mixer_osc_o <= 14'h0000;
        end else begin
            nco_acc0_r              <= nco_step(nco_acc0_r, nco_f0_r);
            nco_acc1_r              <= nco_step(nco_acc1_r, nco_f1_r);
            observation_mixer_osc_o <= ctrl_r[CTRL_NCO_SEL] ? nco_acc1_r : nco_acc0_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack one cycle after the request, unmapped reads zero

    // register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r    <= CTRL_RST;
            delay_a_r <= DELAY_RST;
            delay_b_r <= DELAY_RST;
            nco_f0_r  <= NCO_F_RST;
            nco_f1_r  <= NCO_F_RST;
        end else if (wb_req_s && wb_we_i) begin
            if (wb_adr_i == REG_CTRL) begin
                ctrl_r <= 2'(sel_merge({30'h0, ctrl_r}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == REG_DELAY_A) begin
                delay_a_r <= 13'(sel_merge({19'h0, delay_a_r}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == REG_DELAY_B) begin
                delay_b_r <= 13'(sel_merge({19'h0, delay_b_r}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == REG_NCO_F0) begin
                nco_f0_r <= 14'(sel_merge({18'h0, nco_f0_r}, wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == REG_NCO_F1) begin
                nco_f1_r <= 14'(sel_merge({18'h0, nco_f1_r}, wb_dat_i, wb_sel_i));
            end
        end
    end

    // ack and read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req_s;
            if (wb_req_s && !wb_we_i) begin
                if (wb_adr_i == REG_CTRL) begin
                    wb_dat_o <= {30'h0, ctrl_r};
                end else if (wb_adr_i == REG_DELAY_A) begin
                    wb_dat_o <= {19'h0, delay_a_r};
                end else if (wb_adr_i == REG_DELAY_B) begin
                    wb_dat_o <= {19'h0, delay_b_r};
                end else if (wb_adr_i == REG_NCO_F0) begin
                    wb_dat_o <= {18'h0, nco_f0_r};
                end else if (wb_adr_i == REG_NCO_F1) begin
                    wb_dat_o <= {18'h0, nco_f1_r};
                end else if (wb_adr_i == REG_STATUS) begin
                    wb_dat_o <= {22'h0, lane_src_o, obs_active_o, rx_active_b_o,
                                 rx_active_a_o, tx_active_b_o, tx_active_a_o, en_sync_r[1:0]};
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_TX_A_FOLLOWS_PIN: assert property (
        $rose(tx_path_enable_a_i) ##1 tx_path_enable_a_i [*3] |-> tx_active_a_o)
        else $error("tx chain a not active three cycles after enable rose");
    AST_OBS_STANDBY: assert property (
        $fell(observation_enable_i) ##1 !observation_enable_i [*3] |-> !obs_active_o)
        else $error("observation chain not in standby after enable fell");
    AST_INDEPENDENT: assert property (
        en_sync_r[0] && en_sync_r[2] |=> tx_active_a_o && rx_active_a_o)
        else $error("tx and rx chains not both active together");
    AST_SETTLE_BOUND: assert property (
        $changed(rx_path_enable_b_i) ##1 $stable(rx_path_enable_b_i) [*2]
        |-> ##[0:17] (rx_active_b_o == rx_path_enable_b_i))
        else $error("rx chain b did not settle within 2 us");
    AST_LANE_RX: assert property (
        rx_en_s && !fb_en_s |=> lane_src_o == LANE_RX
                               && serial_out_lane_o == $past(rx_lane_data_i))
        else $error("lanes not carrying rx data");
    AST_LANE_OFF: assert property (
        !rx_en_s && !fb_en_s |=> lane_src_o == LANE_OFF && serial_out_lane_o == 16'h0000)
        else $error("lanes not off with both enables low");
    AST_LANE_BOTH: assert property (
        rx_en_s && fb_en_s |=> lane_src_o == ($past(ctrl_r[CTRL_BOTH_FB]) ? LANE_FB : LANE_RX))
        else $error("both-enabled lane choice ignores control bit");

    AST_FINE_DELAY: assert property (
        en_sync_r[0] && delay_a_r == 13'h0500 && $stable(delay_a_r) [*8]
        |=> tx_a_i_o == $past(tx_a_i_i, 7))
        else $error("fine delay of five clocks not applied");

    AST_NCO_RANGE: assert property (
        nco_acc0_r < NCO_MOD && nco_acc1_r < NCO_MOD)
        else $error("oscillator phase outside 1 kHz raster modulus");

    AST_WB_ACK_ONE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("wishbone ack held for more than one cycle");

    COV_DOWNLINK: cover property (en_sync_r == 5'h13);
    COV_UPLINK: cover property (en_sync_r == 5'h0C);
    COV_BOTH_FB: cover property (rx_en_s && fb_en_s && ctrl_r[CTRL_BOTH_FB]);
    COV_MAX_DELAY: cover property (delay_tap(delay_a_r) == 6'h27 && en_sync_r[0]);

endmodule

/* File: tb/tdm_host_model.sv */
// host-side model that drives the tdd enable pins and the chain lane data
`timescale 1ns/1ps
module tdm_host_model #(
    parameter logic [15:0] RX_WORD = 16'h5A3C,
    parameter logic [15:0] FB_WORD = 16'hC3A5
) (
    input  wire logic        clk_i,
    input  wire logic [1:0]  mode_i,
    output logic      [4:0]  en_o,
    output logic      [15:0] rx_lane_o,
    output logic      [15:0] fb_lane_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // mode bit 0 is downlink, bit 1 uplink; both or neither are legal combinations
    always_comb begin
        en_o = {mode_i[0], mode_i[0], mode_i[1], mode_i[1], mode_i[0]};
    end
    ////////////////////////////////////////////////////////////////////////////////
    // a chain in standby gives no stable word: its lane toggles every cycle
    always_ff @(posedge clk_i) begin
        rx_lane_o <= (en_o[2] | en_o[1]) ? RX_WORD : ~rx_lane_o;
        fb_lane_o <= en_o[0] ? FB_WORD : ~fb_lane_o;
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the tdd mode switch and tx delay block
`timescale 1ns/1ps
module testbench;
    import tdm_pkg::*;
    localparam logic [15:0] RX_WORD = 16'h5A3C;
    localparam logic [15:0] FB_WORD = 16'hC3A5;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              wb_cyc = 1'b0;
    logic              wb_stb = 1'b0;
    logic              wb_we = 1'b0;
    logic [3:0]        wb_sel = 4'hF;
    logic [7:0]        wb_adr = 8'h00;
    logic [31:0]       wb_wdat = 32'h0;
    logic [31:0]       wb_rdat;
    logic              wb_ack;
    logic [1:0]        mode = 2'h0;
    logic [SMP_W-1:0]  smp [4] = '{default: '0};
    logic [SMP_W-1:0]  dout [4];
    logic [4:0]        en;
    logic [4:0]        act;
    logic [LANE_W-1:0] rx_lane;
    logic [LANE_W-1:0] fb_lane;
    logic [LANE_W-1:0] lane;
    logic [2:0]        src;
    logic [NCO_W-1:0]  osc;
    logic [31:0]       rd;
    logic              ctrl_fb = 1'b0;
    int                mismatches = 0;
    int                num_checks = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // design and far-side model
    tdm_core DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .tx_path_enable_a_i(en[4]),
        .tx_path_enable_b_i(en[3]), .rx_path_enable_a_i(en[2]), .rx_path_enable_b_i(en[1]),
        .observation_enable_i(en[0]), .tx_active_a_o(act[4]), .tx_active_b_o(act[3]),
        .rx_active_a_o(act[2]), .rx_active_b_o(act[1]), .obs_active_o(act[0]),
        .tx_a_i_i(smp[0]), .tx_a_q_i(smp[1]), .tx_b_i_i(smp[2]), .tx_b_q_i(smp[3]),
        .tx_a_i_o(dout[0]), .tx_a_q_o(dout[1]), .tx_b_i_o(dout[2]), .tx_b_q_o(dout[3]),
        .rx_lane_data_i(rx_lane), .obs_lane_data_i(fb_lane), .serial_out_lane_o(lane),
        .lane_src_o(src), .observation_mixer_osc_o(osc));
    tdm_host_model #(.RX_WORD(RX_WORD), .FB_WORD(FB_WORD)) host (.clk_i(clk), .mode_i(mode),
        .en_o(en), .rx_lane_o(rx_lane), .fb_lane_o(fb_lane));

    ////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one classic wishbone cycle, entered just after a rising edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= adr;
        wb_wdat <= wd;
        do begin
            @(posedge clk);
        end while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        check($sformatf("reg %h", adr), rd, exp);
    endtask

    // switch pin pattern, old state must hold two edges, new state at the third
    task automatic mode_go(input logic [1:0] m);
        logic [4:0] old;
        logic [2:0] xs;
        old = act;
        xs = (m == 2'h3) ? (ctrl_fb ? LANE_FB : LANE_RX) :
             (m[1] ? LANE_RX : (m[0] ? LANE_FB : LANE_OFF));
        mode <= m;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("active early", 32'(act), 32'(old));
        @(posedge clk);
        @(negedge clk);
        check("active", 32'(act), 32'({m[0], m[0], m[1], m[1], m[0]}));
        check("lane src", 32'(src), 32'(xs));
        if (xs != LANE_OFF) begin
            check("lane data", 32'(lane), 32'((xs == LANE_RX) ? RX_WORD : FB_WORD));
        end
        @(posedge clk);
    endtask

    // impulse through both chains: chain a set by cfg, chain b at zero delay
    task automatic dly(input logic [31:0] cfg, input int tap);
        int seen [4];
        wb(1'b1, REG_DELAY_A, cfg);
        wb(1'b1, REG_DELAY_B, 32'h0);
        repeat (45) @(posedge clk);
        smp <= '{16'h00F1, 16'h00F2, 16'h00F3, 16'h00F4};
        seen = '{default: 0};
        for (int n = 1; n < 50; n++) begin
            @(posedge clk);
            if (n == 1) begin
                smp <= '{default: '0};
            end
            @(negedge clk);
            for (int k = 0; k < 4; k++) begin
                if (dout[k] === 16'h00F1 + 16'(k) && seen[k] == 0) begin
                    seen[k] = n;
                end
            end
        end
        @(posedge clk);
        check("delay a i", 32'(seen[0]), 32'(tap + 2));
        check("delay a q", 32'(seen[1]), 32'(tap + 2));
        check("delay b i", 32'(seen[2]), 32'h2);
        check("delay b q", 32'(seen[3]), 32'h2);
    endtask

    // oscillator advances by the selected frequency word each cycle
    task automatic osc_step(input logic [13:0] f);
        logic [13:0] prev;
        repeat (4) @(posedge clk);
        @(negedge clk);
        prev = osc;
        @(negedge clk);
        check("osc step", 32'(osc), 32'((int'(prev) + int'(f)) % 10000));
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rdchk(REG_CTRL, 32'h0);
        rdchk(REG_DELAY_A, 32'h0);
        rdchk(REG_NCO_F0, 32'h0);
        rdchk(REG_STATUS, 32'h80);
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        rdchk(8'h20, 32'h0);
        wb(1'b1, REG_DELAY_A, 32'hFFFF1F04);
        rdchk(REG_DELAY_A, 32'h1F04);
        // only the low byte is selected: the fine field must keep its value
        wb_sel <= 4'h1;
        wb(1'b1, REG_DELAY_A, 32'h0000_2203);
        wb_sel <= 4'hF;
        rdchk(REG_DELAY_A, 32'h1F03);
        mode_go(2'h1);
        rdchk(REG_STATUS, 32'h24F);
        dly(32'h1F04, 39);
        dly(32'h0007, 8);
        dly(32'h0301, 5);
        dly(32'h0500, 5);
        // second reset in mid-run, then the same delay again
        mode <= 2'h0;
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rdchk(REG_DELAY_A, 32'h0);
        mode_go(2'h1);
        dly(32'h1F04, 39);
        mode_go(2'h2);
        mode_go(2'h3);
        mode_go(2'h0);
        wb(1'b1, REG_CTRL, 32'h1);
        ctrl_fb = 1'b1;
        mode_go(2'h3);
        mode_go(2'h0);
        // frequency words are held fixed while each step is measured
        wb(1'b1, REG_NCO_F0, 32'h1);
        osc_step(14'h0001);
        wb(1'b1, REG_NCO_F1, 32'h270F);
        wb(1'b1, REG_CTRL, 32'h3);
        osc_step(14'h270F);
        end_sim();
    end
endmodule
